/* File: pfm_pkg.sv */
// constants shared by the pad function multiplexer
`default_nettype none
package pfm_pkg;
  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NUM_PADS  = 20;
  localparam int NUM_LOW   = 15;
  localparam int NUM_ALT   = 9;
  localparam int NUM_ISEL  = 4;
  localparam int NUM_FIXED = 4;
  localparam int FSEL_W    = 4;
  localparam int ISEL_W    = 5;
  localparam int CTL_W     = 9;
  localparam int DSE_W     = 3;
  localparam int IDX_W     = 6;
  localparam logic [FSEL_W-1:0] NUM_ALT_F    = 4'h9;
  localparam logic [IDX_W-1:0]  NUM_PADS_I   = 6'h14;
  localparam logic [IDX_W-1:0]  NUM_ISEL_I   = 6'h04;
  localparam logic [ISEL_W-1:0] NUM_PADS_S   = 5'h14;
  // ****************************************************************
  // function select reset values
  // ****************************************************************
  localparam logic [FSEL_W-1:0] ALT_FIVE = 4'h5;
  localparam logic [FSEL_W-1:0] ALT_ZERO = 4'h0;
  // ****************************************************************
  // electrical control fields
  // ****************************************************************
  localparam int CTL_HYS = 0;
  localparam int CTL_PU  = 1;
  localparam int CTL_PD  = 2;
  localparam int CTL_OD  = 3;
  localparam int CTL_DSE = 4;
  localparam int CTL_SRE = 7;
  localparam int CTL_HIZ = 8;
  localparam logic [DSE_W-1:0]    DSE_RST = 3'h1;
  localparam logic [NUM_PADS-1:0] RST_PD  = 20'h49249;
  localparam logic [NUM_PADS-1:0] RST_PU  = 20'h12492;
  localparam logic [NUM_PADS-1:0] RST_HIZ = 20'hc0000;
  localparam logic [ISEL_W-1:0]   ISEL_RST = 5'h00;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam int ADDR_W = 12;
  localparam logic [1:0] REG_FSEL = 2'h0;
  localparam logic [1:0] REG_CTRL = 2'h1;
  localparam logic [1:0] REG_ISEL = 2'h2;
  localparam logic [1:0] REG_STAT = 2'h3;
  localparam logic [ADDR_W-1:0] FSEL_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] CTRL_BASE = 12'h100;
  localparam logic [ADDR_W-1:0] ISEL_BASE = 12'h200;
  localparam logic [ADDR_W-1:0] STAT_OFS  = 12'h300;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic       HRESP_OKAY    = 1'b0;

  function automatic logic [FSEL_W-1:0] pfm_fsel_rst(input int i);
    pfm_fsel_rst = (i < NUM_LOW) ? ALT_ZERO : ALT_FIVE;
  endfunction : pfm_fsel_rst

  function automatic logic [CTL_W-1:0] pfm_ctl_rst(input int i);
    pfm_ctl_rst = {RST_HIZ[i], 1'b0, DSE_RST, 1'b0,
                   RST_PD[i], RST_PU[i], 1'b0};
  endfunction : pfm_ctl_rst
endpackage : pfm_pkg
`default_nettype wire

/* File: pfm_pad_cell.sv */
// one multiplexed pad: function routing and electrical control
`timescale 1ns/10ps
`default_nettype none
module pfm_pad_cell
  import pfm_pkg::*;
(
  input  wire logic [FSEL_W-1:0]  fsel,
  input  wire logic [CTL_W-1:0]   ctrl,
  input  wire logic               hv_io,
  input  wire logic               pad_in,
  input  wire logic [NUM_ALT-1:0] alt_out,
  input  wire logic [NUM_ALT-1:0] alt_oe,
  output logic                    pad_out,
  output logic                    pad_oe,
  output logic                    pad_pu,
  output logic                    pad_pd,
  output logic                    pad_hys,
  output logic [DSE_W-1:0]        pad_dse,
  output logic                    pad_sre,
  output logic [NUM_ALT-1:0]      alt_in
);
  logic sel_out;
  logic sel_oe;

  // ****************************************************************
  // function routing
  // ****************************************************************
  always_comb
  begin
    sel_out = 1'b0;
    sel_oe  = 1'b0;
    alt_in  = '0;
    if (fsel < NUM_ALT_F)
    begin
      sel_out      = alt_out[fsel];
      sel_oe       = alt_oe[fsel];
      alt_in[fsel] = pad_in;
    end
  end

  // ****************************************************************
  // output stage
  // ****************************************************************
  always_comb
  begin
    pad_out = ctrl[CTL_OD] ? 1'b0 : sel_out;
    if (ctrl[CTL_HIZ])
      pad_oe = 1'b0;
    else if (ctrl[CTL_OD])
      pad_oe = sel_oe & ~sel_out;
    else
      pad_oe = sel_oe;
  end

  assign pad_pu  = ctrl[CTL_PU] & ~hv_io;
  assign pad_pd  = ctrl[CTL_PD] & ~hv_io;
  assign pad_hys = ctrl[CTL_HYS];
  assign pad_dse = ctrl[CTL_DSE +: DSE_W];
  assign pad_sre = ctrl[CTL_SRE];
endmodule : pfm_pad_cell
`default_nettype wire

/* File: pfm_top.sv */
// pad function multiplexer with register slave on the system bus
//
// Notes on behaviour
// - each pad routes one of nine functions
// - dedicated high-speed pads bypass all selects
// - per-pad writable function select register
// - shared peripheral inputs pick pad by register
// - function select resets to alternative five on pads 15 to 19
// - fifteen low bank-one pads reset to zero
// - per-pad hysteresis, pulls, drive, slew, open-drain
// - pads 0 to 17 reset with output enable from the selected function, and a pull-down, pull-up or no pull per pad
// - some pads reset as high-impedance outputs
// - pulls ignored on higher-voltage pads
`timescale 1ns/10ps
`default_nettype none
module pfm_top
  import pfm_pkg::*;
(
  input  wire logic                              clk,
  input  wire logic                              rst,
  input  wire logic                              hsel,
  input  wire logic [31:0]                       haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic [31:0]                       hwdata,
  input  wire logic                              hready,
  output logic [31:0]                            hrdata,
  output logic                                   hreadyout,
  output logic                                   hresp,
  input  wire logic [NUM_PADS-1:0]               pad_in,
  input  wire logic [NUM_PADS-1:0]               hv_io,
  output logic [NUM_PADS-1:0]                    pad_out,
  output logic [NUM_PADS-1:0]                    pad_oe,
  output logic [NUM_PADS-1:0]                    pad_pu,
  output logic [NUM_PADS-1:0]                    pad_pd,
  output logic [NUM_PADS-1:0]                    pad_hys,
  output logic [NUM_PADS-1:0][DSE_W-1:0]         pad_dse,
  output logic [NUM_PADS-1:0]                    pad_sre,
  input  wire logic [NUM_PADS-1:0][NUM_ALT-1:0]  alt_out,
  input  wire logic [NUM_PADS-1:0][NUM_ALT-1:0]  alt_oe,
  output logic [NUM_PADS-1:0][NUM_ALT-1:0]       alt_in,
  output logic [NUM_ISEL-1:0]                    shared_in,
  input  wire logic [NUM_FIXED-1:0]              fixed_tx,
  output logic [NUM_FIXED-1:0]                   fixed_pad_out,
  input  wire logic [NUM_FIXED-1:0]              fixed_pad_in,
  output logic [NUM_FIXED-1:0]                   fixed_rx
);
  // ****************************************************************
  // state
  // ****************************************************************
  logic [NUM_PADS-1:0][FSEL_W-1:0] fsel_q;
  logic [NUM_PADS-1:0][CTL_W-1:0]  ctrl_q;
  logic [NUM_ISEL-1:0][ISEL_W-1:0] isel_q;
  logic                            wr_q;
  logic                            rd_q;
  logic [ADDR_W-1:0]               addr_q;
  logic                            take;
  logic [1:0]                      reg_grp;
  logic [IDX_W-1:0]                reg_idx;
  logic                            fsel_wr;
  logic                            ctrl_wr;
  logic                            isel_wr;

  // ****************************************************************
  // bus address phase
  // ****************************************************************
  assign take    = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign reg_grp = addr_q[9:8];
  assign reg_idx = addr_q[7:2];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      addr_q <= '0;
    end
    else
    begin
      wr_q <= take & hwrite;
      rd_q <= take & ~hwrite;
      if (take)
        addr_q <= haddr[ADDR_W-1:0];
    end
  end

  assign hreadyout = 1'b1;
  assign hresp     = HRESP_OKAY;

  assign fsel_wr = wr_q & (reg_grp == REG_FSEL) & (reg_idx < NUM_PADS_I)
                   & (addr_q[11:10] == 2'h0);
  assign ctrl_wr = wr_q & (reg_grp == REG_CTRL) & (reg_idx < NUM_PADS_I)
                   & (addr_q[11:10] == 2'h0);
  assign isel_wr = wr_q & (reg_grp == REG_ISEL) & (reg_idx < NUM_ISEL_I)
                   & (addr_q[11:10] == 2'h0);

  // ****************************************************************
  // function select registers
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_PADS; i++)
        fsel_q[i] <= pfm_fsel_rst(i);
    end
    else if (fsel_wr)
      fsel_q[reg_idx[4:0]] <= hwdata[FSEL_W-1:0];
  end

  // ****************************************************************
  // electrical control registers
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < NUM_PADS; i++)
        ctrl_q[i] <= pfm_ctl_rst(i);
    end
    else if (ctrl_wr)
      ctrl_q[reg_idx[4:0]] <= hwdata[CTL_W-1:0];
  end

  // ****************************************************************
  // input source select registers
  // ****************************************************************
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int j = 0; j < NUM_ISEL; j++)
        isel_q[j] <= ISEL_RST;
    end
    else if (isel_wr)
      isel_q[reg_idx[1:0]] <= hwdata[ISEL_W-1:0];
  end

  // ****************************************************************
  // read data
  // ****************************************************************
  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (rd_q && addr_q[11:10] == 2'h0)
    begin
      unique case (reg_grp)
        REG_FSEL:
          if (reg_idx < NUM_PADS_I)
            hrdata = 32'(fsel_q[reg_idx[4:0]]);
        REG_CTRL:
          if (reg_idx < NUM_PADS_I)
            hrdata = 32'(ctrl_q[reg_idx[4:0]]);
        REG_ISEL:
          if (reg_idx < NUM_ISEL_I)
            hrdata = 32'(isel_q[reg_idx[1:0]]);
        REG_STAT:
          if (reg_idx == 6'h00)
            hrdata = 32'(pad_in);
      endcase
    end
  end

  // ****************************************************************
  // pad cells
  // ****************************************************************
  for (genvar p = 0; p < NUM_PADS; p++)
  begin : g_pad
    pfm_pad_cell u_cell (
      .fsel    (fsel_q[p]),
      .ctrl    (ctrl_q[p]),
      .hv_io   (hv_io[p]),
      .pad_in  (pad_in[p]),
      .alt_out (alt_out[p]),
      .alt_oe  (alt_oe[p]),
      .pad_out (pad_out[p]),
      .pad_oe  (pad_oe[p]),
      .pad_pu  (pad_pu[p]),
      .pad_pd  (pad_pd[p]),
      .pad_hys (pad_hys[p]),
      .pad_dse (pad_dse[p]),
      .pad_sre (pad_sre[p]),
      .alt_in  (alt_in[p])
    );
  end

  // ****************************************************************
  // shared input selection
  // ****************************************************************
  always_comb
  begin
    for (int j = 0; j < NUM_ISEL; j++)
      shared_in[j] = (isel_q[j] < NUM_PADS_S) ?
                     pad_in[isel_q[j]] : 1'b0;
  end

  // ****************************************************************
  // dedicated pads
  // ****************************************************************
  assign fixed_pad_out = fixed_tx;
  assign fixed_rx      = fixed_pad_in;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence s_fsel_write;
    fsel_wr && reg_idx == 6'h02;
  endsequence

  sequence s_ctrl_write;
    ctrl_wr && reg_idx == 6'h02;
  endsequence

  sequence s_isel_write;
    isel_wr && reg_idx == 6'h00;
  endsequence

  a_fsel_low_reset: assert property (
    $past(rst) |-> fsel_q[0] == ALT_ZERO && fsel_q[14] == ALT_ZERO)
    else $error("low bank pad not reset to zero");

  a_fsel_gpio_reset: assert property (
    $past(rst) |-> fsel_q[15] == ALT_FIVE && fsel_q[19] == ALT_FIVE)
    else $error("pad not reset to alternative five");

  a_ctrl_pull_reset: assert property (
    $past(rst) |-> ctrl_q[0][CTL_PD] && ctrl_q[1][CTL_PU]
                   && !ctrl_q[2][CTL_PU] && !ctrl_q[2][CTL_PD])
    else $error("pull reset pattern wrong");

  a_hiz_reset: assert property (
    $past(rst) |-> !pad_oe[18] && !pad_oe[19])
    else $error("high-impedance pad drives after reset");

  a_route_next: assert property (
    s_fsel_write |=> fsel_q[2] == $past(hwdata[FSEL_W-1:0]))
    else $error("function select not taken next cycle");

  a_route_out: assert property (
    fsel_q[16] < NUM_ALT_F && !ctrl_q[16][CTL_OD]
    |-> pad_out[16] == alt_out[16][fsel_q[16]])
    else $error("pad output not from selected function");

  a_one_func: assert property (
    $onehot0(alt_in[2]) && (fsel_q[2] < NUM_ALT_F || alt_in[2] == '0))
    else $error("pad feeds more than one function");

  a_pull_hv: assert property (
    hv_io[5] |-> !pad_pu[5] && !pad_pd[5])
    else $error("pull enabled on high-voltage pad");

  a_shared_in: assert property (
    isel_q[1] < NUM_PADS_S |-> shared_in[1] == pad_in[isel_q[1]])
    else $error("shared input not from selected pad");

  a_fixed_path: assert property (
    fixed_pad_out == fixed_tx && fixed_rx == fixed_pad_in)
    else $error("dedicated pad path altered");

  a_od_drive: assert property (
    ctrl_q[2][CTL_OD] |-> !pad_out[2]
    && !(pad_oe[2] && fsel_q[2] < NUM_ALT_F && alt_out[2][fsel_q[2]]))
    else $error("open-drain pad drives high");

  a_isel_next: assert property (
    s_isel_write |=> isel_q[0] == $past(hwdata[ISEL_W-1:0]))
    else $error("input select not taken next cycle");

  a_ctrl_next: assert property (
    s_ctrl_write |=> ctrl_q[2] == $past(hwdata[CTL_W-1:0]))
    else $error("pad control not taken next cycle");

  a_hiz_drive: assert property (
    ctrl_q[18][CTL_HIZ] |-> !pad_oe[18])
    else $error("high-impedance pad drives");

  a_oe_route: assert property (
    fsel_q[16] < NUM_ALT_F && !ctrl_q[16][CTL_OD] && !ctrl_q[16][CTL_HIZ]
    |-> pad_oe[16] == alt_oe[16][fsel_q[16]])
    else $error("pad enable not from selected function");

  a_no_func: assert property (
    fsel_q[2] >= NUM_ALT_F |-> !pad_oe[2] && !pad_out[2])
    else $error("unused function code drives pad");

  a_elec_pass: assert property (
    pad_dse[2] == ctrl_q[2][CTL_DSE +: DSE_W]
    && pad_sre[2] == ctrl_q[2][CTL_SRE] && pad_hys[2] == ctrl_q[2][CTL_HYS])
    else $error("electrical fields not passed to pad");

  a_pull_lv: assert property (
    !hv_io[1] |-> pad_pu[1] == ctrl_q[1][CTL_PU])
    else $error("pull lost on lower-voltage pad");
endmodule : pfm_top
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench for the pad function multiplexer
`timescale 1ns/10ps
`default_nettype none
module tb_top
  import pfm_pkg::*;
();
  // ****************************************************************
  // signals and instance
  // ****************************************************************
  logic                             clk, rst, hsel, hwrite;
  logic                             hreadyout, hresp;
  logic [31:0]                      haddr, hwdata, hrdata, rq;
  logic [1:0]                       htrans;
  logic [2:0]                       hsize;
  logic [NUM_PADS-1:0]              pad_in, hv_io, pad_out, pad_oe;
  logic [NUM_PADS-1:0]              pad_pu, pad_pd, pad_hys, pad_sre;
  logic [NUM_PADS-1:0][DSE_W-1:0]   pad_dse;
  logic [NUM_PADS-1:0][NUM_ALT-1:0] alt_out, alt_oe, alt_in;
  logic [NUM_ISEL-1:0]              shared_in;
  logic [NUM_FIXED-1:0]             fixed_tx, fixed_pad_out;
  logic [NUM_FIXED-1:0]             fixed_pad_in, fixed_rx;
  logic [CTL_W-1:0]                 ce;
  int                               n_fail, total_checks, i;

  pfm_top dut_u (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pad_in(pad_in), .hv_io(hv_io), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pu(pad_pu), .pad_pd(pad_pd), .pad_hys(pad_hys),
    .pad_dse(pad_dse), .pad_sre(pad_sre), .alt_out(alt_out),
    .alt_oe(alt_oe), .alt_in(alt_in), .shared_in(shared_in),
    .fixed_tx(fixed_tx), .fixed_pad_out(fixed_pad_out),
    .fixed_pad_in(fixed_pad_in), .fixed_rx(fixed_rx)
  );

  always #5 clk = ~clk;

  // ****************************************************************
  // tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // address phase held until hready, data phase until hready again
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'b1)
      @(posedge clk);
    rq = hrdata;
  endtask : bus

  function automatic logic [31:0] ad(input logic [ADDR_W-1:0] b,
                                     input int n);
    ad = {20'h0, b} + 32'(4 * n);
  endfunction : ad

  task automatic rd_chk(input logic [31:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rq, e);
  endtask : rd_chk

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  // ****************************************************************
  // watchdog
  // ****************************************************************
  initial
  begin
    repeat (5000) @(posedge clk);
    n_fail++;
    stop_test();
  end

  // ****************************************************************
  // tests
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    pad_in = '1;
    hv_io = '0;
    alt_out = '1;
    alt_oe = '1;
    fixed_tx = '0;
    fixed_pad_in = '0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values of all registers and pads
    for (i = 0; i < NUM_PADS; i++)
    begin
      ce = {RST_HIZ[i], 1'b0, DSE_RST, 1'b0, RST_PD[i], RST_PU[i], 1'b0};
      rd_chk(ad(FSEL_BASE, i), (i < NUM_LOW) ? 32'h0 : 32'h5);
      rd_chk(ad(CTRL_BASE, i), {23'h0, ce});
      chk({23'h0, alt_in[i]}, (i < NUM_LOW) ? 32'h1 : 32'h20);
    end
    for (i = 0; i < NUM_ISEL; i++)
      rd_chk(ad(ISEL_BASE, i), 32'h0);
    chk({12'h0, pad_oe}, {12'h0, ~RST_HIZ});
    chk({12'h0, pad_pd}, {12'h0, RST_PD});
    chk({12'h0, pad_pu}, {12'h0, RST_PU});
    hv_io <= '1;
    @(negedge clk);
    chk({12'h0, pad_pu | pad_pd}, 32'h0);
    rd_chk({20'h0, STAT_OFS}, 32'h000fffff);
    rd_chk(32'h00000400, 32'h0);
    chk({30'h0, hresp, hreadyout}, 32'h1);
    $display("test reset done");
    // every function on one pad, in effect the cycle after the write
    for (i = 0; i < NUM_ALT; i++)
    begin
      bus(1'b1, ad(FSEL_BASE, 2), 32'(i));
      alt_out <= 180'h1 << (NUM_ALT * 2 + i);
      @(negedge clk);
      chk({31'h0, pad_out[2]}, 32'h1);
      chk({23'h0, alt_in[2]}, 32'h1 << i);
    end
    $display("test routing done");
    // electrical control: hys, od, dse 7, slew bit set
    bus(1'b1, ad(CTRL_BASE, 2), 32'h000000f9);
    alt_out <= '1;
    @(negedge clk);
    chk({26'h0, pad_hys[2], pad_dse[2], pad_sre[2], pad_oe[2]},
        32'h0000003e);
    @(posedge clk);
    alt_out <= '0;
    @(negedge clk);
    chk({30'h0, pad_oe[2], pad_out[2]}, 32'h2);
    rd_chk(ad(CTRL_BASE, 2), 32'h000000f9);
    // weakest drive with the slew bit clear, as software should pick
    bus(1'b1, ad(CTRL_BASE, 3), 32'h00000010);
    @(negedge clk);
    chk({28'h0, pad_dse[3], pad_sre[3]}, 32'h2);
    // an unused function code leaves the pad disconnected
    bus(1'b1, ad(FSEL_BASE, 2), 32'h9);
    @(negedge clk);
    chk({22'h0, pad_oe[2], alt_in[2]}, 32'h0);
    $display("test control done");
    // shared inputs pick distinct pads
    for (i = 0; i < NUM_ISEL; i++)
      bus(1'b1, ad(ISEL_BASE, i), 32'(7 + i));
    for (i = 0; i < NUM_ISEL; i++)
    begin
      @(posedge clk);
      pad_in <= 20'h1 << (7 + i);
      @(negedge clk);
      chk({28'h0, shared_in}, 32'h1 << i);
    end
    $display("test input select done");
    // dedicated lanes ignore every select
    @(posedge clk);
    fixed_tx <= 4'ha;
    fixed_pad_in <= 4'h5;
    @(negedge clk);
    chk({24'h0, fixed_pad_out, fixed_rx}, 32'h000000a5);
    $display("test dedicated done");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
